// File: fault_irq_defines.svh
// constants for the fault, interrupt and clock status register bank
// assumes a 50 MHz system clock and byte-wide control port registers
`ifndef FAULT_IRQ_DEFINES_SVH
`define FAULT_IRQ_DEFINES_SVH

// ----------------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------------
`define OFS_RATIO_DETECT_HIGH 8'h40
`define OFS_RATIO_DETECT_LOW 8'h41
`define OFS_IRQ_SETUP 8'h42
`define OFS_DAC_FAULT_POLICY 8'h43
`define OFS_DAC_POWER_TUNING 8'h4f

// ----------------------------------------------------------------------------
// reset values and writable masks
// ----------------------------------------------------------------------------
`define RST_IRQ_SETUP 8'h00
`define RST_DAC_FAULT_POLICY 8'h50
`define RST_DAC_POWER_TUNING 8'h00
`define WMASK_DAC_FAULT_POLICY 8'h77
`define WMASK_DAC_POWER_TUNING 8'ha6

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RATIO_W 14
`define RATIO_HIGH_W 6
`define FAULT_FLAG_BIT 3

// ----------------------------------------------------------------------------
// sizes and timing
// ----------------------------------------------------------------------------
`define EVENT_W 8
`define IN_CH 4
`define DAC_CH 2
`define CLK_KHZ 50000
`define IRQ_PULSE_MS 2
`define IRQ_PERIOD_MS 4
`define IRQ_CNT_W 18

`endif

// File: fault_irq_pkg.sv
// types for the fault, interrupt and clock status register bank
// assumes fault_irq_defines.svh supplies the numeric constants
package fault_irq_pkg;

  typedef enum logic [1:0] {
    IRQ_LATCHED,
    IRQ_LIVE,
    IRQ_REPEAT,
    IRQ_PULSE
  } irq_mode_e;

  typedef struct packed {
    logic irq_polarity;
    irq_mode_e mode;
    logic [1:0] input_fault_powerdown_sel;
    logic latched_readback_sel;
    logic input_fault_recovery_sel;
    logic latched_clear_on_read_sel;
  } irq_setup_s;

  typedef struct packed {
    logic rsvd7;
    logic [1:0] dac_fault_powerdown_sel;
    logic dac_fault_recovery_sel;
    logic dac_fault_off_flag;
    logic powerup_fault_guard_off;
    logic dac_fault_detect_off;
    logic regulator_short_detect_off;
  } dac_policy_s;

  typedef struct packed {
    logic modulator_clock_halve;
    logic rsvd6;
    logic fir_segmenter_skip;
    logic [1:0] rsvd4_3;
    logic lowpower_filter_sel;
    logic reference_current_scale;
    logic rsvd0;
  } power_tuning_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_s;

endpackage

// File: fault_powerdown.sv
// per-channel power-down hold on faults with auto or manual recovery
// assumes fault and mask vectors synchronous to sys_clk, mask bit 1 = masked
`timescale 1ns/1ps
`include "fault_irq_defines.svh"

module fault_powerdown #(
  parameter int N = 2
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [1:0] sel,
  input wire logic manual,
  input wire logic rearm,
  input wire logic [N-1:0] fault,
  input wire logic [N-1:0] fault_mask,
  output logic [N-1:0] held
);

  // --------------------------------------------------------------------------
  // trigger selection, reserved code ignores faults
  // --------------------------------------------------------------------------
  wire logic [N-1:0] trig = (sel == 2'h1) ? (fault & ~fault_mask) :
                            (sel == 2'h2) ? fault : '0;

  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_ch
      wire logic held_nxt = trig[i] | (held[i] & (manual ? ~rearm : fault[i]));
      always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
          held[i] <= 1'b0;
        end else begin
          held[i] <= held_nxt;
        end
      end
    end
  endgenerate

endmodule

// File: irq_output.sv
// interrupt pin generator: level, live, repeating and one-shot pulse modes
// assumes event inputs synchronous to sys_clk
`timescale 1ns/1ps
`include "fault_irq_defines.svh"

module irq_output #(
  parameter logic [`IRQ_CNT_W-1:0] PULSE_CYC = 18'h186a0,
  parameter logic [`IRQ_CNT_W-1:0] PERIOD_CYC = 18'h30d40
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire fault_irq_pkg::irq_mode_e mode,
  input wire logic polarity,
  input wire logic latched_any,
  input wire logic live_any,
  input wire logic event_pulse,
  output logic irq_pin
);

  logic [`IRQ_CNT_W-1:0] cnt_r;
  logic [`IRQ_CNT_W-1:0] cnt_nxt;
  logic active;

  // --------------------------------------------------------------------------
  // mode timing
  // --------------------------------------------------------------------------
  always_comb begin
    cnt_nxt = '0;
    active = 1'b0;
    case (mode)
      fault_irq_pkg::IRQ_LATCHED: begin
        active = latched_any;
      end
      fault_irq_pkg::IRQ_LIVE: begin
        active = live_any;
      end
      fault_irq_pkg::IRQ_REPEAT: begin
        active = latched_any && (cnt_r < PULSE_CYC);
        cnt_nxt = (!latched_any || cnt_r == PERIOD_CYC - 1'b1) ? '0 : cnt_r + 1'b1;
      end
      default: begin
        // each unmasked event (re)starts one pulse
        active = (cnt_r != '0);
        cnt_nxt = event_pulse ? PULSE_CYC : (active ? cnt_r - 1'b1 : '0);
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      irq_pin <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      irq_pin <= polarity ? active : ~active;
    end
  end

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_repeat_low_half: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == fault_irq_pkg::IRQ_REPEAT && latched_any && cnt_r >= PULSE_CYC) |=> (irq_pin == ~$past(polarity)))
    else $error("repeat mode asserted outside its first half");
  a_pulse_one_shot: assert property (@(posedge sys_clk) disable iff (!rst_n)
    (mode == fault_irq_pkg::IRQ_PULSE && event_pulse) |=> ##1 (irq_pin == $past(polarity)))
    else $error("pulse mode missed an event");

endmodule

// File: fault_irq_regs.sv
// register bank: ratio detect status, interrupt setup, fault policy, tuning
// assumes the control port delivers one-cycle byte read and write strobes
// Summary of operation
// - Ratio upper six bits read at 0x40 bits 5..0.
// - Ratio lower eight bits read at 0x41.
// - Interrupt pin active low at polarity 0, active high at 1.
// - Mode 0: interrupt follows any unmasked latched event.
// - Mode 1: interrupt follows any unmasked live condition.
// - Mode 2: interrupt 2 ms active per 4 ms while latched events remain.
// - Mode 3: one 2 ms pulse per unmasked event.
// - Input channel fault power-down: off, unmasked, all, reserved.
// - Latched readback shows all events, or only unmasked at 1.
// - Input channels auto re-power at 0, stay off at 1.
// - Read clears latches where live is zero, or all at 1.
// - DAC fault power-down select, reset 10b.
// - DAC recovery bit resets 1; manual at 1, auto at 0.
// - Status bit shows any DAC channel held off by fault.
// - Power-up driver fault powers DAC down unless guard bit set.
// - DAC driver and short faults ignored when detect-off set.
// - Regulator short detection stops when its disable bit set.
// - Modulator clock 3 MHz at 0, 1.5 MHz at 1.
// - FIR and segmenter bypassed when bypass bit set.
// - Low-power DAC filter selected when its bit set.
// - Reference current Vref/R at 0, Vref/2R at 1.
`timescale 1ns/1ps
`include "fault_irq_defines.svh"

module fault_irq_regs #(
  parameter logic [`IRQ_CNT_W-1:0] PULSE_CYC = `IRQ_CNT_W'(`IRQ_PULSE_MS * `CLK_KHZ),
  parameter logic [`IRQ_CNT_W-1:0] PERIOD_CYC = `IRQ_CNT_W'(`IRQ_PERIOD_MS * `CLK_KHZ)
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire fault_irq_pkg::reg_req_s reg_req,
  output logic [7:0] reg_rdata,
  input wire logic [`RATIO_W-1:0] ratio_value,
  input wire logic ratio_valid,
  input wire logic [`EVENT_W-1:0] event_live,
  input wire logic [`EVENT_W-1:0] event_mask,
  input wire logic latch_read,
  output logic [`EVENT_W-1:0] latch_view,
  output logic irq_out_low_active,
  input wire logic [`IN_CH-1:0] input_fault,
  input wire logic [`IN_CH-1:0] input_fault_mask,
  input wire logic input_rearm,
  output logic [`IN_CH-1:0] input_powerdown,
  input wire logic [`DAC_CH-1:0] dac_driver_fault,
  input wire logic [`DAC_CH-1:0] dac_short_fault,
  input wire logic [`DAC_CH-1:0] dac_fault_mask,
  input wire logic dac_powering_up,
  output logic [`DAC_CH-1:0] dac_powerdown,
  input wire logic regulator_short_raw,
  output logic regulator_short_flag,
  output logic modulator_clock_halve,
  output logic fir_segmenter_skip,
  output logic lowpower_filter_sel,
  output logic reference_current_scale
);

  // --------------------------------------------------------------------------
  // reset release
  // --------------------------------------------------------------------------
  logic rst_meta_r;
  logic rst_n;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end

  // --------------------------------------------------------------------------
  // register storage
  // --------------------------------------------------------------------------
  logic [`RATIO_W-1:0] ratio_r;
  fault_irq_pkg::irq_setup_s setup_r;
  fault_irq_pkg::dac_policy_s policy_r;
  fault_irq_pkg::power_tuning_s tuning_r;
  logic [`EVENT_W-1:0] latch_r;
  logic [`EVENT_W-1:0] live_prev_r;
  logic [`EVENT_W-1:0] latch_nxt;
  logic [7:0] rdata_nxt;

  wire logic wr_setup = reg_req.wr && reg_req.addr == `OFS_IRQ_SETUP;
  wire logic wr_policy = reg_req.wr && reg_req.addr == `OFS_DAC_FAULT_POLICY;
  wire logic wr_tuning = reg_req.wr && reg_req.addr == `OFS_DAC_POWER_TUNING;

  // reserved bits keep their reset values; writes never reach the read-only flag bit, which tracks any_dac_held
  wire logic [7:0] policy_wr = (reg_req.wdata & `WMASK_DAC_FAULT_POLICY) |
                               (`RST_DAC_FAULT_POLICY & ~`WMASK_DAC_FAULT_POLICY);
  wire logic [7:0] tuning_wr = (reg_req.wdata & `WMASK_DAC_POWER_TUNING) |
                               (`RST_DAC_POWER_TUNING & ~`WMASK_DAC_POWER_TUNING);

  // --------------------------------------------------------------------------
  // fault gating and power-down policy
  // --------------------------------------------------------------------------
  wire logic dac_faults_on = ~policy_r.dac_fault_detect_off;
  wire logic guard = dac_powering_up & policy_r.powerup_fault_guard_off;
  wire logic [`DAC_CH-1:0] dac_fault =
    ({`DAC_CH{dac_faults_on & ~guard}} & dac_driver_fault) |
    ({`DAC_CH{dac_faults_on}} & dac_short_fault);
  wire logic dac_rearm = wr_policy;
  wire logic any_dac_held = |dac_powerdown;

  fault_powerdown #(.N(`IN_CH)) u_input_pd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(setup_r.input_fault_powerdown_sel),
    .manual(setup_r.input_fault_recovery_sel),
    .rearm(input_rearm),
    .fault(input_fault),
    .fault_mask(input_fault_mask),
    .held(input_powerdown)
  );

  fault_powerdown #(.N(`DAC_CH)) u_dac_pd (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .sel(policy_r.dac_fault_powerdown_sel),
    .manual(policy_r.dac_fault_recovery_sel),
    .rearm(dac_rearm),
    .fault(dac_fault),
    .fault_mask(dac_fault_mask),
    .held(dac_powerdown)
  );

  // --------------------------------------------------------------------------
  // event latches and interrupt
  // --------------------------------------------------------------------------
  wire logic [`EVENT_W-1:0] event_rise = event_live & ~live_prev_r;
  wire logic [`EVENT_W-1:0] live_on = event_live & ~event_mask;
  wire logic [`EVENT_W-1:0] latch_clr = !latch_read ? '0 :
    (setup_r.latched_clear_on_read_sel ? '1 : ~event_live);
  wire logic latched_any = |(latch_r & ~event_mask);
  wire logic event_pulse = |(event_rise & ~event_mask);

  // set on a rising condition, so a clear-all read can drop a live bit; set wins
  assign latch_nxt = (latch_r & ~latch_clr) | event_rise;

  irq_output #(.PULSE_CYC(PULSE_CYC), .PERIOD_CYC(PERIOD_CYC)) u_irq (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .mode(setup_r.mode),
    .polarity(setup_r.irq_polarity),
    .latched_any(latched_any),
    .live_any(|live_on),
    .event_pulse(event_pulse),
    .irq_pin(irq_out_low_active)
  );

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  always_comb begin
    rdata_nxt = 8'h00;
    if (reg_req.addr == `OFS_RATIO_DETECT_HIGH) begin
      rdata_nxt = {2'h0, ratio_r[`RATIO_W-1 -: `RATIO_HIGH_W]};
    end else if (reg_req.addr == `OFS_RATIO_DETECT_LOW) begin
      rdata_nxt = ratio_r[7:0];
    end else if (reg_req.addr == `OFS_IRQ_SETUP) begin
      rdata_nxt = setup_r;
    end else if (reg_req.addr == `OFS_DAC_FAULT_POLICY) begin
      rdata_nxt = policy_r;
    end else if (reg_req.addr == `OFS_DAC_POWER_TUNING) begin
      rdata_nxt = tuning_r;
    end
  end

  // --------------------------------------------------------------------------
  // sequential state
  // --------------------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ratio_r <= '0;
    end else if (ratio_valid) begin
      ratio_r <= ratio_value;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      setup_r <= `RST_IRQ_SETUP;
    end else if (wr_setup) begin
      setup_r <= reg_req.wdata;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tuning_r <= `RST_DAC_POWER_TUNING;
    end else if (wr_tuning) begin
      tuning_r <= tuning_wr;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      latch_r <= '0;
      live_prev_r <= '0;
    end else begin
      latch_r <= latch_nxt;
      live_prev_r <= event_live;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_req.rd) begin
      reg_rdata <= rdata_nxt;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      policy_r <= `RST_DAC_FAULT_POLICY;
    end else begin
      if (wr_policy) begin
        policy_r <= policy_wr;
      end
      policy_r.dac_fault_off_flag <= any_dac_held;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign latch_view = setup_r.latched_readback_sel ? (latch_r & ~event_mask) : latch_r;
  assign regulator_short_flag = regulator_short_raw & ~policy_r.regulator_short_detect_off;
  assign modulator_clock_halve = tuning_r.modulator_clock_halve;
  assign fir_segmenter_skip = tuning_r.fir_segmenter_skip;
  assign lowpower_filter_sel = tuning_r.lowpower_filter_sel;
  assign reference_current_scale = tuning_r.reference_current_scale;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_ratio_update;
    ratio_valid ##1 !ratio_valid
      ##1 (reg_req.rd && reg_req.addr == `OFS_RATIO_DETECT_HIGH && !ratio_valid);
  endsequence

  a_ratio_high_read: assert property (s_ratio_update |=>
    reg_rdata == 8'($past(ratio_value, 3) >> 8))
    else $error("ratio upper byte not the captured value");

  a_ratio_low_read: assert property ((reg_req.rd && reg_req.addr == `OFS_RATIO_DETECT_LOW) |=>
    reg_rdata == $past(ratio_r[7:0]))
    else $error("ratio lower byte mismatch");

  a_irq_latched_level: assert property ((setup_r.mode == fault_irq_pkg::IRQ_LATCHED && $stable(setup_r))
    |=> irq_out_low_active == ($past(latched_any) ~^ $past(setup_r.irq_polarity)))
    else $error("interrupt level does not follow latched events");

  a_irq_live_level: assert property ((setup_r.mode == fault_irq_pkg::IRQ_LIVE && $stable(setup_r))
    |=> irq_out_low_active == ($past(|live_on) ~^ $past(setup_r.irq_polarity)))
    else $error("interrupt level does not follow live events");

  a_latch_set_wins: assert property ((latch_read && $rose(event_live[0])) |=> latch_r[0])
    else $error("event lost on clearing read");

  a_latch_read_clear: assert property ((latch_read && latch_r[0] && !event_live[0])
    |=> !latch_r[0])
    else $error("latched bit survived a read with live status zero");

  a_latch_clear_all: assert property ((latch_read && setup_r.latched_clear_on_read_sel && latch_r[0]
    && !$rose(event_live[0])) |=> !latch_r[0])
    else $error("live bit kept by a clear-all read");

  a_fault_flag_track: assert property (any_dac_held [*2] |=> policy_r.dac_fault_off_flag)
    else $error("fault power-down status not shown");

  a_dac_detect_off: assert property ((policy_r.dac_fault_detect_off && $stable(policy_r.dac_fault_detect_off)
    && !$past(any_dac_held)) |-> !any_dac_held)
    else $error("dac powered down with detection off");

  a_reg_short_gate: assert property (policy_r.regulator_short_detect_off |-> !regulator_short_flag)
    else $error("regulator short reported while disabled");

  a_readback_masked: assert property (setup_r.latched_readback_sel |-> (latch_view & event_mask) == '0)
    else $error("masked event visible in readback");

  a_input_take_all: assert property ((setup_r.input_fault_powerdown_sel == 2'h2 && input_fault[0])
    |=> input_powerdown[0])
    else $error("input fault ignored with all faults selected");

  a_input_manual_hold: assert property ((setup_r.input_fault_recovery_sel && !input_rearm
    && input_powerdown[2]) |=> input_powerdown[2])
    else $error("manual input channel re-powered");

  a_dac_manual_hold: assert property ((policy_r.dac_fault_recovery_sel && !wr_policy && dac_powerdown[0])
    |=> dac_powerdown[0])
    else $error("manual dac channel re-powered");

  a_dac_auto_free: assert property ((!policy_r.dac_fault_recovery_sel && !dac_driver_fault[1]
    && !dac_short_fault[1]) |=> !dac_powerdown[1])
    else $error("auto dac channel kept off");

endmodule

// File: host_ctrl_model.sv
// host side of the control port: one-cycle byte register writes and reads
// assumes strobes are sampled on the rising edge and read data lands one edge later
`timescale 1ns/1ps

module host_ctrl_model (
  input wire logic sys_clk,
  output fault_irq_pkg::reg_req_s reg_req,
  input wire logic [7:0] reg_rdata
);
  initial reg_req = '0;

  // ---------------------------------------------------------------------------
  // control port cycles
  // ---------------------------------------------------------------------------
  // reserved fields carry reset values unless a test writes past them on purpose
  task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge sys_clk);
    reg_req.addr = a;
    reg_req.wdata = d;
    reg_req.wr = 1'b1;
    @(negedge sys_clk);
    reg_req.wr = 1'b0;
    reg_req.wdata = ~d;
  endtask

  // read data is taken on the falling edge after the one that drops the strobe
  task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
    @(negedge sys_clk);
    reg_req.addr = a;
    reg_req.rd = 1'b1;
    @(negedge sys_clk);
    reg_req.rd = 1'b0;
    reg_req.addr = ~a;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
endmodule

// File: fault_irq_regs_tb.sv
// self-checking bench for the fault, interrupt and clock status register bank
// assumes host_ctrl_model drives the control port; all other inputs change on falling edges
`timescale 1ns/1ps

module fault_irq_regs_tb;
  logic sys_clk;
  logic resetn;
  fault_irq_pkg::reg_req_s reg_req;
  logic [7:0] reg_rdata, latch_view, rd, event_live, event_mask;
  logic [13:0] ratio_value;
  logic ratio_valid, latch_read, input_rearm, dac_powering_up, regulator_short_raw;
  logic [3:0] input_fault, input_fault_mask, input_powerdown;
  logic [1:0] dac_driver_fault, dac_short_fault, dac_fault_mask, dac_powerdown;
  logic irq_out_low_active, regulator_short_flag, modulator_clock_halve, fir_segmenter_skip;
  logic lowpower_filter_sel, reference_current_scale;
  int fail_count = 0;
  int checks_done = 0;
  int cycles = 0;
  int c;
  logic [3:0] in_exp [4] = '{4'h0, 4'h2, 4'h3, 4'h0};
  logic [1:0] dac_exp [4] = '{2'h0, 2'h2, 2'h3, 2'h0};
  wire logic [7:0] tune = {4'h0, modulator_clock_halve, fir_segmenter_skip, lowpower_filter_sel,
                           reference_current_scale};
  wire logic [7:0] pin = {7'h0, irq_out_low_active};

  host_ctrl_model host (.sys_clk(sys_clk), .reg_req(reg_req), .reg_rdata(reg_rdata));

  fault_irq_regs #(.PULSE_CYC(18'h00004), .PERIOD_CYC(18'h00008)) DUT (
    .sys_clk(sys_clk), .resetn(resetn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .ratio_value(ratio_value), .ratio_valid(ratio_valid), .event_live(event_live),
    .event_mask(event_mask), .latch_read(latch_read), .latch_view(latch_view),
    .irq_out_low_active(irq_out_low_active), .input_fault(input_fault),
    .input_fault_mask(input_fault_mask), .input_rearm(input_rearm), .input_powerdown(input_powerdown),
    .dac_driver_fault(dac_driver_fault), .dac_short_fault(dac_short_fault),
    .dac_fault_mask(dac_fault_mask), .dac_powering_up(dac_powering_up), .dac_powerdown(dac_powerdown),
    .regulator_short_raw(regulator_short_raw), .regulator_short_flag(regulator_short_flag),
    .modulator_clock_halve(modulator_clock_halve), .fir_segmenter_skip(fir_segmenter_skip),
    .lowpower_filter_sel(lowpower_filter_sel), .reference_current_scale(reference_current_scale)
  );

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ---------------------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------------------
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    checks_done++;
    if (g !== e) begin
      fail_count++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic nc(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    host.read_reg(a, rd);
    chk(rd, e);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    host.write_reg(a, d);
  endtask

  // one-cycle live event, then time for latch and pin to settle
  task automatic evt(input logic [7:0] m);
    event_live = m;
    nc(1);
    event_live = 8'h00;
    nc(3);
  endtask

  task automatic clr();
    latch_read = 1'b1;
    nc(1);
    latch_read = 1'b0;
    nc(3);
  endtask

  // cycles with the pin at its active level
  task automatic cnt(input int n, input logic act, output int k);
    k = 0;
    repeat (n) begin
      @(negedge sys_clk);
      if (irq_out_low_active === act) k++;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      end_of_test();
    end
  end

  // ---------------------------------------------------------------------------
  // tests
  // ---------------------------------------------------------------------------
  initial begin
    resetn = 1'b0;
    ratio_value = '0;
    ratio_valid = 1'b0;
    event_live = '0;
    event_mask = '0;
    latch_read = 1'b0;
    input_fault = '0;
    input_fault_mask = 4'h1;
    input_rearm = 1'b0;
    dac_driver_fault = '0;
    dac_short_fault = '0;
    dac_fault_mask = 2'h1;
    dac_powering_up = 1'b0;
    regulator_short_raw = 1'b0;
    nc(4);
    resetn = 1'b1;
    nc(3);
    chk(pin, 8'h01);
    chk(tune, 8'h00);
    rdc(8'h40, 8'h00);
    rdc(8'h41, 8'h00);
    rdc(8'h42, 8'h00);
    rdc(8'h43, 8'h50);
    rdc(8'h4f, 8'h00);
    rdc(8'h50, 8'h00);
    $display("test reset values done");
    ratio_value = 14'h2abc;
    ratio_valid = 1'b1;
    nc(1);
    ratio_valid = 1'b0;
    ratio_value = 14'h1543;
    rdc(8'h40, 8'h2a);
    rdc(8'h41, 8'hbc);
    wr(8'h40, 8'hff);
    wr(8'h41, 8'h00);
    rdc(8'h41, 8'hbc);
    rdc(8'h40, 8'h2a);
    ratio_valid = 1'b1;
    nc(1);
    ratio_valid = 1'b0;
    rdc(8'h41, 8'h43);
    rdc(8'h40, 8'h15);
    $display("test ratio done");
    wr(8'h4f, 8'hff);
    rdc(8'h4f, 8'ha6);
    chk(tune, 8'h0f);
    wr(8'h4f, 8'h24);
    chk(tune, 8'h06);
    wr(8'h4f, 8'h82);
    chk(tune, 8'h09);
    wr(8'h43, 8'hff);
    rdc(8'h43, 8'h77);
    wr(8'h43, 8'h50);
    $display("test tuning done");
    evt(8'h01);
    chk(pin, 8'h00);
    chk(latch_view, 8'h01);
    wr(8'h42, 8'h80);
    nc(2);
    chk(pin, 8'h01);
    clr();
    chk(latch_view, 8'h00);
    chk(pin, 8'h00);
    event_live = 8'h02;
    nc(2);
    clr();
    chk(latch_view, 8'h02);
    event_live = 8'h00;
    clr();
    chk(latch_view, 8'h00);
    wr(8'h42, 8'h81);
    event_live = 8'h01;
    clr();
    chk(latch_view, 8'h01);
    clr();
    chk(latch_view, 8'h00);
    event_live = 8'h00;
    event_mask = 8'h08;
    evt(8'h08);
    chk(pin, 8'h00);
    chk(latch_view, 8'h08);
    wr(8'h42, 8'h84);
    chk(latch_view, 8'h00);
    event_mask = 8'h00;
    nc(3);
    chk(latch_view, 8'h08);
    chk(pin, 8'h01);
    clr();
    $display("test latched mode done");
    wr(8'h42, 8'h20);
    event_live = 8'h10;
    nc(3);
    chk(pin, 8'h00);
    event_live = 8'h00;
    nc(3);
    chk(pin, 8'h01);
    event_mask = 8'h10;
    event_live = 8'h10;
    nc(3);
    chk(pin, 8'h01);
    event_live = 8'h00;
    event_mask = 8'h00;
    clr();
    wr(8'h42, 8'h40);
    evt(8'h01);
    cnt(8, 1'b0, c);
    chk(8'(c), 8'h04);
    cnt(8, 1'b0, c);
    chk(8'(c), 8'h04);
    clr();
    nc(2);
    cnt(8, 1'b0, c);
    chk(8'(c), 8'h00);
    wr(8'h42, 8'he0);
    event_live = 8'h02;
    cnt(12, 1'b1, c);
    chk(8'(c), 8'h04);
    event_live = 8'h00;
    nc(1);
    event_mask = 8'h02;
    event_live = 8'h02;
    cnt(12, 1'b1, c);
    chk(8'(c), 8'h00);
    event_live = 8'h00;
    event_mask = 8'h00;
    clr();
    $display("test event modes done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h42, 8'(s) << 3);
      input_fault = 4'h3;
      nc(3);
      chk({4'h0, input_powerdown}, {4'h0, in_exp[s]});
      input_fault = 4'h0;
      nc(3);
      chk({4'h0, input_powerdown}, 8'h00);
    end
    wr(8'h42, 8'h12);
    input_fault = 4'h4;
    nc(3);
    input_fault = 4'h0;
    nc(3);
    chk({4'h0, input_powerdown}, 8'h04);
    input_rearm = 1'b1;
    nc(1);
    input_rearm = 1'b0;
    nc(3);
    chk({4'h0, input_powerdown}, 8'h00);
    $display("test input power-down done");
    for (int s = 0; s < 4; s++) begin
      wr(8'h43, 8'(s) << 5);
      dac_driver_fault = 2'h3;
      nc(3);
      chk({6'h0, dac_powerdown}, {6'h0, dac_exp[s]});
      dac_driver_fault = 2'h0;
      nc(3);
      chk({6'h0, dac_powerdown}, 8'h00);
    end
    wr(8'h43, 8'h50);
    dac_short_fault = 2'h1;
    nc(3);
    dac_short_fault = 2'h0;
    nc(3);
    chk({6'h0, dac_powerdown}, 8'h01);
    rdc(8'h43, 8'h58);
    wr(8'h43, 8'h50);
    nc(3);
    chk({6'h0, dac_powerdown}, 8'h00);
    rdc(8'h43, 8'h50);
    wr(8'h43, 8'h42);
    dac_driver_fault = 2'h3;
    dac_short_fault = 2'h3;
    nc(3);
    chk({6'h0, dac_powerdown}, 8'h00);
    dac_driver_fault = 2'h0;
    dac_short_fault = 2'h0;
    wr(8'h43, 8'h44);
    dac_powering_up = 1'b1;
    dac_driver_fault = 2'h2;
    nc(3);
    chk({6'h0, dac_powerdown}, 8'h00);
    wr(8'h43, 8'h40);
    nc(3);
    chk({6'h0, dac_powerdown}, 8'h02);
    dac_driver_fault = 2'h0;
    dac_powering_up = 1'b0;
    nc(3);
    regulator_short_raw = 1'b1;
    nc(1);
    chk({7'h0, regulator_short_flag}, 8'h01);
    wr(8'h43, 8'h41);
    chk({7'h0, regulator_short_flag}, 8'h00);
    regulator_short_raw = 1'b0;
    $display("test dac fault policy done");
    end_of_test();
  end
endmodule
